// ==== core/pcsb_params.svh ====
// Purpose: Offsets, field positions, reset values, bus commands and timing code
// Assumes: Byte offsets inside configuration space of one function
// Notes:   Definitions only
`ifndef PCSB_PARAMS_SVH
`define PCSB_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define PCSB_CMD_OFFSET   8'h04
`define PCSB_STAT_OFFSET  8'h06
`define PCSB_REV_OFFSET   8'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PCSB_CMD_IO_BIT     0
`define PCSB_CMD_PERR_BIT   6
`define PCSB_CMD_SERR_BIT   8
`define PCSB_ST_PARDET_BIT  15
`define PCSB_ST_SERRSIG_BIT 14
`define PCSB_ST_TABORT_BIT  11
`define PCSB_ST_STATUS_LSB  16

// ------------------------------------------------------------
// Reset and fixed values
// ------------------------------------------------------------
`define PCSB_CMD_RESET      16'h0000
`define PCSB_STAT_FIXED     16'h0280
`define PCSB_REV_DEFAULT    8'h01

// ------------------------------------------------------------
// Bus commands and timing
// ------------------------------------------------------------
`define PCSB_BUSCMD_IO_RD   4'h2
`define PCSB_BUSCMD_IO_WR   4'h3
`define PCSB_DEVSEL_MEDIUM  2'h1

`endif

// ==== core/pcsb_pkg.sv ====
// Purpose: Types shared by the command/status bank and the claim logic
// Assumes: Nothing beyond the params header
// Notes:   Constants live in pcsb_params.svh
package pcsb_pkg;

   // ------------------------------------------------------------
   // Claim sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CLM_IDLE    = 2'b00,   // Waiting for an address phase
      CLM_WAIT    = 2'b01,   // Decode clock, select not yet driven
      CLM_DRIVE   = 2'b10,   // Select driven low
      CLM_RELEASE = 2'b11    // Select driven high before float
   } pcsb_claim_e;

   // Claim sequencer state
   typedef struct packed {
      pcsb_claim_e state;
   } pcsb_claim_s;

   // Bank state: writable enables, sticky flags, pin drive, read port
   typedef struct packed {
      logic        io_en;       // I/O space response enable
      logic        perr_en;     // Parity error response enable
      logic        serr_en;     // System error response enable
      logic        par_det;     // Parity error detected flag
      logic        serr_sig;    // System error signalled flag
      logic        tabort_sig;  // Target abort signalled flag
      logic        serr_drive;  // System error pin driven low
      logic        perr_low;    // Parity error pin driven low
      logic        perr_high;   // Parity error pin driven high
      logic        rvalid;      // Read data valid
      logic [31:0] rdata;       // Read data word
   } pcsb_bank_s;

endpackage : pcsb_pkg

// ==== core/pcsb_claim.sv ====
// Purpose: Claims I/O cycles in range with medium select timing
// Assumes: Address phase, command and range hit come from bus logic
// Notes:   Memory and special cycles are never claimed
`include "pcsb_params.svh"

module pcsb_claim (
   input  wire logic       i_clk,         // Bus clock
   input  wire logic       i_nrst,        // Synchronous reset, low
   input  wire logic       i_io_en,       // I/O space response enable
   input  wire logic       i_addr_phase,  // Address phase pulse
   input  wire logic [3:0] i_bus_cmd,     // Bus command of address phase
   input  wire logic       i_io_hit,      // Address inside I/O range
   input  wire logic       i_xfer_done,   // Last data phase completed
   output logic            o_devsel_out,  // Select pin level
   output logic            o_devsel_oe,   // Select pin driven
   output logic            o_claimed      // Transaction claimed
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pcsb_pkg::pcsb_claim_s s_reg;   // Registered state
   pcsb_pkg::pcsb_claim_s s_next;  // Next state
   logic                  io_cmd;  // Command is an I/O access

   // Only I/O commands qualify; special and memory cycles drop out
   assign io_cmd = (i_bus_cmd == `PCSB_BUSCMD_IO_RD) ||
                   (i_bus_cmd == `PCSB_BUSCMD_IO_WR);

   // Next state logic
   always_comb begin
      s_next = s_reg;
      case (s_reg.state)
         pcsb_pkg::CLM_IDLE: begin
            // Gate on the enable so a disabled function stays silent
            if (i_addr_phase && io_cmd && i_io_hit && i_io_en) begin
               s_next.state = pcsb_pkg::CLM_WAIT;
            end
         end
         pcsb_pkg::CLM_WAIT: begin
            // One idle decode clock gives medium timing
            s_next.state = pcsb_pkg::CLM_DRIVE;
         end
         pcsb_pkg::CLM_DRIVE: begin
            if (i_xfer_done) begin
               s_next.state = pcsb_pkg::CLM_RELEASE;
            end
         end
         pcsb_pkg::CLM_RELEASE: begin
            // Driven high once so the shared line rises sharply
            s_next.state = pcsb_pkg::CLM_IDLE;
         end
         default: begin
            s_next.state = pcsb_pkg::CLM_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Pin drive follows the state
   assign o_devsel_oe  = s_reg.state[1];
   assign o_devsel_out = (s_reg.state == pcsb_pkg::CLM_RELEASE);
   assign o_claimed    = (s_reg.state != pcsb_pkg::CLM_IDLE);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_devsel_medium: assert property (
      (s_reg.state == pcsb_pkg::CLM_IDLE) && i_addr_phase && io_cmd && i_io_hit && i_io_en
      |=> !o_devsel_oe ##1 (o_devsel_oe && !o_devsel_out))
      else $error("select not driven at medium timing");

   a_no_foreign_claim: assert property (
      (s_reg.state == pcsb_pkg::CLM_IDLE) && i_addr_phase && !(io_cmd && i_io_en)
      |=> ##1 !o_devsel_oe)
      else $error("claimed a cycle that must be ignored");

   c_claim_done: cover property (o_devsel_oe && !o_devsel_out ##1 o_devsel_out);

endmodule : pcsb_claim

// ==== core/pcsb_bank.sv ====
// Purpose: Command, status and revision registers of a target function
// Assumes: Config cycles arrive as one-cycle read/write strobes
// Notes:   Error events come from bus logic on the same clock
//
// Notes on behaviour
// - Reserved command and status bits read zero
// - Fast back-to-back master enable reads zero
// - Address parity error drives SERR# when enabled
// - Data parity error drives PERR# when enabled
// - Address/data stepping bit reads zero
// - Palette snoop bit reads zero
// - Write-and-invalidate enable reads zero
// - Special cycle bit zero; special cycles ignored
// - Initiator bit read-only; never a master
// - Memory response bit zero; memory never claimed
// - I/O response bit writable, gates I/O claim
// - Parity error flag sticky on any detection
// - System error flag sticky when SERR# driven
// - Target abort flag sticky when abort signalled
// - Master-only status flags read zero
// - Select decode speed reads medium, 01
// - Fast back-to-back target capable reads one
// - User features and high speed bits zero
// - Writing one clears flag, zero keeps
// - Revision identifier read at offset 08h
`include "pcsb_params.svh"

module pcsb_bank #(
   parameter logic [7:0] SILICON_REVISION = `PCSB_REV_DEFAULT  // Arbitrary value
) (
   input  wire logic        i_clk,           // Bus clock, 25 MHz
   input  wire logic        i_nrst,          // Synchronous reset, low
   input  wire logic        i_cfg_rd,        // Config read strobe
   input  wire logic        i_cfg_wr,        // Config write strobe
   input  wire logic [7:0]  i_cfg_addr,      // Config byte address
   input  wire logic [3:0]  i_cfg_be,        // Byte enables, high
   input  wire logic [31:0] i_cfg_wdata,     // Config write data
   output logic      [31:0] o_cfg_rdata,     // Config read data
   output logic             o_cfg_rvalid,    // Read data valid pulse
   input  wire logic        i_addr_par_err,  // Address parity error pulse
   input  wire logic        i_data_par_err,  // Data parity error pulse
   input  wire logic        i_target_abort,  // Target abort signalled
   input  wire logic        i_addr_phase,    // Address phase pulse
   input  wire logic [3:0]  i_bus_cmd,       // Bus command
   input  wire logic        i_io_hit,        // Address in I/O range
   input  wire logic        i_xfer_done,     // Transaction finished
   output logic             o_serr_out,      // SERR# level
   output logic             o_serr_oe,       // SERR# driven
   output logic             o_perr_out,      // PERR# level
   output logic             o_perr_oe,       // PERR# driven
   output logic             o_devsel_out,    // DEVSEL# level
   output logic             o_devsel_oe,     // DEVSEL# driven
   output logic             o_claimed,       // Transaction claimed
   output logic             o_io_space_en    // I/O response enabled
);

   // ------------------------------------------------------------
   // Layout of the command/status dword
   // ------------------------------------------------------------
   //   [0]     I/O space response, writable
   //   [1]     Memory space response, zero
   //   [2]     Initiator enable, zero
   //   [3]     Special cycle response, zero
   //   [4]     Write-invalidate enable, zero
   //   [5]     Palette snoop, zero
   //   [6]     Parity error response, writable
   //   [7]     Stepping, zero
   //   [8]     System error response, writable
   //   [9]     Fast b2b master enable, zero
   //   [15:10] Reserved, zero
   //   [20:16] Reserved, zero
   //   [21]    High speed capable, zero
   //   [22]    User features flag, zero
   //   [23]    Fast b2b target capable, one
   //   [24]    Master data parity flag, zero
   //   [26:25] Select decode speed, medium
   //   [27]    Target abort signalled, clear by one
   //   [28]    Target abort received, zero
   //   [29]    Master abort signalled, zero
   //   [30]    System error signalled, clear by one
   //   [31]    Parity error detected, clear by one
   // All three sticky flags sit in byte lane 3.
   // Dword 08h carries only the revision in [7:0].

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Compare the dword part of an address with a register offset
   function automatic logic dword_is(input logic [7:0] addr,
                                     input logic [7:0] offset);
      dword_is = (addr[7:2] == offset[7:2]);
   endfunction : dword_is

   // Command half word; unlisted bits are hard zero
   function automatic logic [15:0] pack_cmd(input pcsb_pkg::pcsb_bank_s st);
      logic [15:0] v;
      v = `PCSB_CMD_RESET;
      v[`PCSB_CMD_IO_BIT]   = st.io_en;
      v[`PCSB_CMD_PERR_BIT] = st.perr_en;
      v[`PCSB_CMD_SERR_BIT] = st.serr_en;
      pack_cmd = v;
   endfunction : pack_cmd

   // Status half word over the fixed capability pattern
   function automatic logic [15:0] pack_stat(input pcsb_pkg::pcsb_bank_s st);
      logic [15:0] v;
      v = `PCSB_STAT_FIXED;
      v[`PCSB_ST_PARDET_BIT]  = st.par_det;
      v[`PCSB_ST_SERRSIG_BIT] = st.serr_sig;
      v[`PCSB_ST_TABORT_BIT]  = st.tabort_sig;
      pack_stat = v;
   endfunction : pack_stat

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pcsb_pkg::pcsb_bank_s s_reg;    // Registered state
   pcsb_pkg::pcsb_bank_s s_next;   // Next state
   logic                 wr_cmd;   // Write to command/status dword
   logic                 clr_par;  // Clear parity flag
   logic                 clr_serr; // Clear system error flag
   logic                 clr_tab;  // Clear target abort flag
   logic                 set_par;  // Parity error detected now
   logic                 set_serr; // SERR# drive starts now

   // Command and status share one dword; status is the upper half
   assign wr_cmd = i_cfg_wr && dword_is(i_cfg_addr, `PCSB_CMD_OFFSET);

   // Clear only on a one in an enabled status byte lane
   assign clr_par  = wr_cmd && i_cfg_be[3] &&
                     i_cfg_wdata[`PCSB_ST_STATUS_LSB + `PCSB_ST_PARDET_BIT];
   assign clr_serr = wr_cmd && i_cfg_be[3] &&
                     i_cfg_wdata[`PCSB_ST_STATUS_LSB + `PCSB_ST_SERRSIG_BIT];
   // Status bits 15:8, abort flag included, travel in lane 3
   assign clr_tab  = wr_cmd && i_cfg_be[3] &&
                     i_cfg_wdata[`PCSB_ST_STATUS_LSB + `PCSB_ST_TABORT_BIT];

   // Flag is raised by any detection, enabled or not
   assign set_par  = i_addr_par_err || i_data_par_err;
   // Disabled errors are simply dropped
   assign set_serr = i_addr_par_err && s_reg.serr_en;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------

   // Writes, sticky flags, pin drive and read port
   always_comb begin
      s_next = s_reg;
      // Only writable enables take data; read-only lanes drop out
      if (wr_cmd && i_cfg_be[0]) begin
         s_next.io_en   = i_cfg_wdata[`PCSB_CMD_IO_BIT];
         s_next.perr_en = i_cfg_wdata[`PCSB_CMD_PERR_BIT];
      end
      if (wr_cmd && i_cfg_be[1]) begin
         s_next.serr_en = i_cfg_wdata[`PCSB_CMD_SERR_BIT];
      end
      // Set beats clear so an event in the clearing cycle survives
      s_next.par_det    = (s_reg.par_det & ~clr_par) | set_par;
      s_next.serr_sig   = (s_reg.serr_sig & ~clr_serr) | set_serr;
      s_next.tabort_sig = (s_reg.tabort_sig & ~clr_tab) | i_target_abort;
      // SERR# is open drain: one clock low, then released
      s_next.serr_drive = set_serr;
      // PERR# is driven low, then high for one clock before floating
      s_next.perr_low   = i_data_par_err && s_reg.perr_en;
      // A fresh error restarts the low phase instead of going high
      s_next.perr_high  = s_reg.perr_low && !s_next.perr_low;
      // Read port answers one clock after the strobe
      s_next.rvalid = i_cfg_rd;
      if (i_cfg_rd) begin
         if (dword_is(i_cfg_addr, `PCSB_CMD_OFFSET)) begin
            s_next.rdata = {pack_stat(s_reg), pack_cmd(s_reg)};
         end else if (dword_is(i_cfg_addr, `PCSB_REV_OFFSET)) begin
            // Class code lanes belong to other logic and read zero here
            s_next.rdata = {24'h000000, SILICON_REVISION};
         end else begin
            s_next.rdata = 32'h00000000;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_cfg_rdata   = s_reg.rdata;
   assign o_cfg_rvalid  = s_reg.rvalid;
   assign o_serr_out    = 1'b0;
   assign o_serr_oe     = s_reg.serr_drive;
   assign o_perr_out    = s_reg.perr_high;
   assign o_perr_oe     = s_reg.perr_low | s_reg.perr_high;
   assign o_io_space_en = s_reg.io_en;
   // Pins give level and enable only; the board pull-ups
   // own the idle level, so a floating line reads high.

   // Target-only claim; no request line exists, so no master cycles
   pcsb_claim u_claim (
      .i_clk        (i_clk),
      .i_nrst       (i_nrst),
      .i_io_en      (s_reg.io_en),
      .i_addr_phase (i_addr_phase),
      .i_bus_cmd    (i_bus_cmd),
      .i_io_hit     (i_io_hit),
      .i_xfer_done  (i_xfer_done),
      .o_devsel_out (o_devsel_out),
      .o_devsel_oe  (o_devsel_oe),
      .o_claimed    (o_claimed)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Reads of the command/status and revision dwords seen one clock later
   logic rd_cmd_q;  // Helper for checks
   logic rd_rev_q;  // Helper for checks
   always_ff @(posedge i_clk) begin
      rd_cmd_q <= i_cfg_rd && dword_is(i_cfg_addr, `PCSB_CMD_OFFSET);
      rd_rev_q <= i_cfg_rd && dword_is(i_cfg_addr, `PCSB_REV_OFFSET);
   end

   a_cmd_reserved: assert property (
      o_cfg_rvalid && rd_cmd_q |-> (o_cfg_rdata[15:10] == 6'h00) && (o_cfg_rdata[20:16] == 5'h00))
      else $error("reserved bits not zero");

   a_cmd_ro_bits: assert property (
      o_cfg_rvalid && rd_cmd_q |-> (o_cfg_rdata[9] == 1'b0) && (o_cfg_rdata[7] == 1'b0)
                                  && (o_cfg_rdata[5:1] == 5'h00))
      else $error("read-only command bit not zero");

   a_stat_fixed: assert property (
      o_cfg_rvalid && rd_cmd_q |-> (o_cfg_rdata[29:28] == 2'h0) && (o_cfg_rdata[24] == 1'b0)
                                  && (o_cfg_rdata[26:25] == `PCSB_DEVSEL_MEDIUM)
                                  && (o_cfg_rdata[23:21] == 3'h4))
      else $error("fixed status field wrong");

   a_serr_drive: assert property (
      o_serr_oe |-> $past(i_addr_par_err) && $past(s_reg.serr_en) && s_reg.serr_sig)
      else $error("SERR# driven without enabled cause");

   a_serr_on_err: assert property (
      i_addr_par_err && s_reg.serr_en |=> o_serr_oe && !o_serr_out ##1 (!o_serr_oe || $past(set_serr)))
      else $error("SERR# pulse missing");

   a_perr_sequence: assert property (
      i_data_par_err && s_reg.perr_en |=> (o_perr_oe && !o_perr_out) ##1
                                          (o_perr_oe && (o_perr_out || $past(i_data_par_err && s_reg.perr_en))))
      else $error("PERR# sequence wrong");

   a_perr_cause: assert property (
      o_perr_oe && !o_perr_out |-> $past(i_data_par_err) && $past(s_reg.perr_en))
      else $error("PERR# driven without enabled cause");

   a_par_sticky: assert property (
      s_reg.par_det && !clr_par |=> s_reg.par_det)
      else $error("parity flag lost");

   a_tabort_set: assert property (
      i_target_abort |=> s_reg.tabort_sig)
      else $error("target abort flag not set");

   a_tab_set_wins: assert property (
      clr_tab && i_target_abort |=> s_reg.tabort_sig)
      else $error("abort flag lost to clear");

   a_tab_clear: assert property (
      clr_tab && !i_target_abort |=> !s_reg.tabort_sig)
      else $error("abort flag not cleared");

   a_serr_flag: assert property (
      set_serr |=> s_reg.serr_sig)
      else $error("system error flag not set");

   a_serr_clear: assert property (
      clr_serr && !set_serr |=> !s_reg.serr_sig)
      else $error("system error flag not cleared");

   a_cmd_lane_lo: assert property (
      wr_cmd && !i_cfg_be[0] |=> (s_reg.io_en == $past(s_reg.io_en)) && (s_reg.perr_en == $past(s_reg.perr_en)))
      else $error("unenabled low lane changed");

   a_w1c_clear: assert property (
      clr_par && !set_par |=> !s_reg.par_det)
      else $error("write one did not clear flag");

   a_w1c_keep: assert property (
      wr_cmd && i_cfg_be[3] && !i_cfg_wdata[31] && s_reg.par_det |=> s_reg.par_det)
      else $error("write zero changed flag");

   a_rev_read: assert property (
      o_cfg_rvalid && rd_rev_q |-> o_cfg_rdata == {24'h000000, SILICON_REVISION})
      else $error("revision read wrong");

   a_io_write: assert property (
      wr_cmd && i_cfg_be[0] |=> o_io_space_en == $past(i_cfg_wdata[0]))
      else $error("I/O enable not written");

   a_lane_kept: assert property (
      wr_cmd && !i_cfg_be[1] |=> s_reg.serr_en == $past(s_reg.serr_en))
      else $error("unenabled lane changed");

   c_serr_pulse: cover property (i_addr_par_err && s_reg.serr_en ##1 o_serr_oe);
   c_perr_pulse: cover property (o_perr_oe && !o_perr_out ##1 o_perr_out);
   c_clear_flag: cover property (s_reg.par_det ##1 clr_par ##1 !s_reg.par_det);
   c_set_vs_clr: cover property (clr_tab && i_target_abort);

endmodule : pcsb_bank

// ==== testbench/pcsb_host.sv ====
// Purpose: Host bridge model issuing config and I/O bus cycles
// Assumes: Requests change at the falling edge, taken at the rising edge
// Notes:   Released write data and command are inverted, never left stale
module pcsb_host (
   input  wire logic        i_clk,         // Bus clock
   input  wire logic        i_rvalid,      // Read data valid
   input  wire logic [31:0] i_rdata,       // Read data
   output logic             o_cfg_rd,      // Config read strobe
   output logic             o_cfg_wr,      // Config write strobe
   output logic [7:0]       o_cfg_addr,    // Config byte address
   output logic [3:0]       o_cfg_be,      // Byte enables
   output logic [31:0]      o_cfg_wdata,   // Write data
   output logic             o_addr_phase,  // Address phase pulse
   output logic [3:0]       o_bus_cmd,     // Bus command
   output logic             o_io_hit,      // Address in I/O range
   output logic             o_xfer_done    // Last data phase done
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------
   initial begin
      {o_cfg_rd, o_cfg_wr, o_addr_phase, o_io_hit, o_xfer_done} = 5'h00;
      o_cfg_addr  = 8'h00;
      o_cfg_be    = 4'h0;
      o_cfg_wdata = 32'h0000_0000;
      o_bus_cmd   = 4'h0;
   end

   // Config write; the host alone turns on the I/O response bit
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge i_clk);
      o_cfg_wr    = 1'b1;
      o_cfg_addr  = a;
      o_cfg_be    = be;
      o_cfg_wdata = d;
      @(negedge i_clk);
      o_cfg_wr    = 1'b0;
      o_cfg_wdata = ~d;    // Stale data must not look valid
   endtask : cfg_write

   // Config read; answer is due exactly one cycle after the strobe
   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic v);
      @(negedge i_clk);
      o_cfg_rd   = 1'b1;
      o_cfg_addr = a;
      @(negedge i_clk);
      o_cfg_rd   = 1'b0;
      d          = i_rdata;
      v          = i_rvalid;
   endtask : cfg_read

   // Address phase of an I/O-range transaction
   task automatic io_start(input logic [3:0] cmd);
      @(negedge i_clk);
      o_addr_phase = 1'b1;
      o_bus_cmd    = cmd;
      o_io_hit     = 1'b1;
      @(negedge i_clk);
      o_addr_phase = 1'b0;
      o_bus_cmd    = ~cmd;
      o_io_hit     = 1'b0;
   endtask : io_start

   // Last data phase completes
   task automatic io_end;
      @(negedge i_clk);
      o_xfer_done = 1'b1;
      @(negedge i_clk);
      o_xfer_done = 1'b0;
   endtask : io_end
endmodule : pcsb_host

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the command/status bank
// Assumes: Inputs driven at the falling edge, reset held 20 cycles
// Notes:   Revision value is arbitrary; expectations derive from it
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] REV = 8'h5a;  // Arbitrary value
   logic i_clk, i_nrst, rv, rvalid, perr_out, perr_oe, serr_out, serr_oe, dv_out, dv_oe, claimed, io_en;
   logic [2:0] errs;  // Address parity, data parity, target abort
   logic [31:0] rd_data, rdata, wdata;
   logic [7:0] addr;
   logic [3:0] be, cmd;
   logic cfg_rd, cfg_wr, aph, hit, done;
   int n_mismatch, total_checks;
   logic [3:0] cmd_list [5] = '{4'h2, 4'h3, 4'h6, 4'h1, 4'h7};  // I/O pair, memory, special, memory

   // ----------------------------------------------------------
   // Clock, device and host
   // ----------------------------------------------------------
   always #20 i_clk = ~i_clk;
   pcsb_bank #(.SILICON_REVISION(REV)) pcsb_bank_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_cfg_rd(cfg_rd),
      .i_cfg_wr(cfg_wr), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
      .o_cfg_rvalid(rvalid), .i_addr_par_err(errs[0]), .i_data_par_err(errs[1]), .i_target_abort(errs[2]),
      .i_addr_phase(aph), .i_bus_cmd(cmd), .i_io_hit(hit), .i_xfer_done(done), .o_serr_out(serr_out),
      .o_serr_oe(serr_oe), .o_perr_out(perr_out), .o_perr_oe(perr_oe), .o_devsel_out(dv_out),
      .o_devsel_oe(dv_oe), .o_claimed(claimed), .o_io_space_en(io_en));
   pcsb_host pcsb_host_i (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_cfg_rd(cfg_rd),
      .o_cfg_wr(cfg_wr), .o_cfg_addr(addr), .o_cfg_be(be), .o_cfg_wdata(wdata), .o_addr_phase(aph),
      .o_bus_cmd(cmd), .o_io_hit(hit), .o_xfer_done(done));

   // Read and compare, including the valid pulse
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      pcsb_host_i.cfg_read(a, rd_data, rv);
      `CHK("rdata", ex, rd_data)
      `CHK("rvalid", 1'b1, rv)
      @(negedge i_clk);
      `CHK("rvalid_end", 1'b0, rvalid)
   endtask : rd

   // One-cycle error pulse; returns just after the taking edge
   task automatic err(input logic [2:0] e);
      @(negedge i_clk);
      errs = e;
      @(negedge i_clk);
      errs = 3'h0;
   endtask : err

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   // Watchdog sized well beyond the hundred or so cycles the tests take
   initial begin
      repeat (3000) @(posedge i_clk);
      n_mismatch++;
      final_report();
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      i_clk  = 1'b0;
      i_nrst = 1'b0;
      errs   = 3'h0;
      repeat (20) @(posedge i_clk);
      @(negedge i_clk);
      i_nrst = 1'b1;
      `CHK("io_en", 1'b0, io_en)
      rd(8'h04, 32'h0280_0000);
      rd(8'h08, {24'h0, REV});
      rd(8'h10, 32'h0000_0000);
      pcsb_host_i.cfg_write(8'h04, 4'hf, 32'h0000_ffff);
      `CHK("io_en", 1'b1, io_en)
      rd(8'h04, 32'h0280_0141);
      err(3'b001);
      `CHK("serr_oe", 1'b1, serr_oe)
      `CHK("serr_out", 1'b0, serr_out)
      err(3'b010);
      `CHK("serr_oe", 1'b0, serr_oe)
      `CHK("perr", 2'b10, {perr_oe, perr_out})
      @(negedge i_clk);
      `CHK("perr", 2'b11, {perr_oe, perr_out})
      err(3'b100);
      `CHK("perr_oe", 1'b0, perr_oe)
      rd(8'h04, 32'hca80_0141);
      pcsb_host_i.cfg_write(8'h04, 4'hc, 32'h0000_0000);
      rd(8'h04, 32'hca80_0141);
      pcsb_host_i.cfg_write(8'h04, 4'hc, 32'hffff_0000);
      rd(8'h04, 32'h0280_0141);
      pcsb_host_i.cfg_write(8'h04, 4'h3, 32'h0000_0001);
      err(3'b011);
      `CHK("pins", 2'b00, {serr_oe, perr_oe})
      rd(8'h04, 32'h8280_0001);
      // Abort raised in the clearing cycle survives; lane 3 alone clears
      fork
         pcsb_host_i.cfg_write(8'h04, 4'h8, 32'hffff_0000);
         err(3'b100);
      join
      rd(8'h04, 32'h0a80_0001);
      pcsb_host_i.cfg_write(8'h04, 4'h8, 32'hffff_0000);
      rd(8'h04, 32'h0280_0001);
      // I/O read and write are claimed; memory read, special and memory write not
      foreach (cmd_list[i]) begin
         logic [3:0] c;
         logic       ex;
         c  = cmd_list[i];
         ex = (c == 4'h2) || (c == 4'h3);
         pcsb_host_i.io_start(c);
         `CHK("claim", {ex, 1'b0}, {claimed, dv_oe})
         @(negedge i_clk);
         `CHK("devsel", {ex, 1'b0}, {dv_oe, dv_out})
         pcsb_host_i.io_end();
         `CHK("devsel", {ex, ex}, {dv_oe, dv_out})
         @(negedge i_clk);
         `CHK("float", 2'b00, {dv_oe, claimed})
      end
      pcsb_host_i.cfg_write(8'h04, 4'h3, 32'h0000_0000);
      pcsb_host_i.io_start(4'h2);
      `CHK("claim_off", 1'b0, claimed)
      @(negedge i_clk);
      `CHK("devsel_off", 1'b0, dv_oe)
      final_report();
   end
endmodule : tb_top
